// File: ddi_pkg.sv
// Constants and types shared by the descriptor interpreter files
package ddi_pkg;
	// ********************************************************
	// Register map
	// ********************************************************
	localparam logic [7:0] DDI_OFS_CTRL = 8'h00;
	localparam logic [7:0] DDI_OFS_BASE = 8'h04;
	localparam logic [7:0] DDI_OFS_STATUS = 8'h08;
	localparam logic [7:0] DDI_OFS_CUR = 8'h0c;
	localparam logic [7:0] DDI_OFS_INT_STAT = 8'h10;
	localparam logic [7:0] DDI_OFS_INT_MASK = 8'h14;
	// Control register fields
	localparam int DDI_CTRL_EN = 0;
	localparam int DDI_CTRL_DIR_LO = 1;
	localparam int DDI_CTRL_INIT = 3;
	localparam int DDI_CTRL_BCAST = 4;
	localparam logic [1:0] DDI_DIR_M2D = 2'h0;
	localparam logic [1:0] DDI_DIR_M2M = 2'h1;
	localparam logic [1:0] DDI_DIR_D2M = 2'h2;
	// ********************************************************
	// Descriptor layout
	// ********************************************************
	localparam int DDI_F_CNT_LO = 16;
	localparam int DDI_F_BUF = 5;
	localparam int DDI_F_CONT = 4;
	localparam int DDI_F_CRC_KEEP = 3;
	localparam int DDI_F_IRQ = 2;
	localparam logic [1:0] DDI_ACT_HALT = 2'h0;
	localparam logic [1:0] DDI_ACT_NEXT = 2'h1;
	localparam logic [1:0] DDI_ACT_RESTART = 2'h2;
	localparam logic [1:0] DDI_ACT_REPEAT = 2'h3;
	localparam logic [31:0] DDI_ENTRY_DEV = 32'h0000_0008;
	localparam logic [31:0] DDI_ENTRY_M2M = 32'h0000_0010;
	localparam logic [1:0] DDI_LAST_DEV = 2'h1;
	localparam logic [1:0] DDI_LAST_M2M = 2'h3;
	localparam logic [31:0] DDI_WORD_BYTES = 32'h0000_0004;
	// Interrupt status bits
	localparam int DDI_INT_N = 3;
	localparam int DDI_INT_DESC = 0;
	localparam int DDI_INT_BUF_FULL = 1;
	localparam int DDI_INT_HALT = 2;
	// Reset values
	localparam logic [31:0] DDI_RST_WORD = 32'h0000_0000;
	localparam logic [15:0] DDI_RST_CNT = 16'h0000;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_FETCH = 4'h1,
		ST_CHECK = 4'h2,
		ST_WAIT_BCAST = 4'h3,
		ST_WAIT_REQ = 4'h4,
		ST_START = 4'h5,
		ST_XFER = 4'h6,
		ST_WRBACK = 4'h7,
		ST_NEXT = 4'h8
	} ddi_state_e;
endpackage

// File: ddi_sync.sv
// Two-stage synchroniser with rising-edge pulse output
`timescale 1ns/10ps
module ddi_sync
	import ddi_pkg::*;
#(
	parameter int W = 2
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] din,
	output logic [W-1:0] rise
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	// Only s2 and s3 feed the edge detector; s1 may be metastable
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end
		else
		begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign rise = s2_q & ~s3_q;
endmodule

// File: ddi_irq.sv
// Sticky interrupt status, write-one-to-clear, with mask
`timescale 1ns/10ps
module ddi_irq
	import ddi_pkg::*;
#(
	parameter int N = 3
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [N-1:0] set,
	input wire logic clr_wr,
	input wire logic mask_wr,
	input wire logic [N-1:0] wdata,
	output logic [N-1:0] status,
	output logic [N-1:0] mask,
	output logic irq
);
	logic [N-1:0] stat_q;
	logic [N-1:0] stat_d;
	logic [N-1:0] mask_q;
	logic irq_q;
	wire [N-1:0] clr = clr_wr ? wdata : '0;
	// A new event beats a clear in the same cycle
	assign stat_d = set | (stat_q & ~clr);
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stat_q <= '0;
			mask_q <= '0;
			irq_q <= 1'b0;
		end
		else
		begin
			stat_q <= stat_d;
			if (mask_wr)
				mask_q <= wdata;
			irq_q <= |(stat_d & (mask_wr ? wdata : mask_q));
		end
	end
	assign status = stat_q;
	assign mask = mask_q;
	assign irq = irq_q;
endmodule

// File: ddi_desc_interp.sv
// Descriptor-mode sequencer of one DMA channel
// Summary of operation
// - Descriptor is two words, four for m2m
// - M2m source from word 0; else ignored
// - Bits 31:0 give transfer address, bits 95:64 m2m destination
// - Count field holds bytes minus one
// - Write actual bytes moved minus one back
// - Memory-to-device completion clears buffer flag
// - Device-to-memory completion sets buffer flag
// - Device modes never read empty nor write full buffer
// - Continuation bit starts next entry automatically
// - Without continuation wait for fresh request
// - First entry always needs explicit request
// - Checksum reset per transfer unless bit 3
// - Bit 2 raises descriptor interrupt on completion
// - Action code halts, advances, restarts or repeats
// - Entries spaced 8 or 16 bytes, control last
// - Not ready: wait broadcast, reload whole descriptor
`timescale 1ns/10ps
module ddi_desc_interp
	import ddi_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	output logic MEM_REQ,
	output logic MEM_WE,
	output logic [31:0] MEM_ADDR,
	output logic [31:0] MEM_WDATA,
	input wire logic [31:0] MEM_RDATA,
	input wire logic MEM_ACK,
	input wire logic DEV_REQ,
	input wire logic BCAST_IN,
	output logic BCAST_OUT,
	output logic XFER_START,
	output logic [1:0] XFER_DIR,
	output logic [31:0] XFER_SRC,
	output logic [31:0] XFER_DST,
	output logic [15:0] XFER_CNT,
	output logic XFER_CRC_CLR,
	input wire logic XFER_DONE,
	input wire logic [15:0] XFER_MOVED,
	output logic IRQ
);
	// ********************************************************
	// Register bus
	// ********************************************************
	ddi_state_e state_q;
	logic en_q;
	logic [1:0] dir_q;
	logic [31:0] base_q;
	logic [31:0] cur_q;
	logic [31:0] rdata_q;
	logic first_q;
	logic cont_q;
	logic [DDI_INT_N-1:0] int_set;
	logic [DDI_INT_N-1:0] int_stat;
	logic [DDI_INT_N-1:0] int_mask;
	logic [1:0] pin_rise;
	wire wr_ctrl = REG_WR && REG_ADDR == DDI_OFS_CTRL;
	wire wr_base = REG_WR && REG_ADDR == DDI_OFS_BASE;
	wire wr_istat = REG_WR && REG_ADDR == DDI_OFS_INT_STAT;
	wire wr_imask = REG_WR && REG_ADDR == DDI_OFS_INT_MASK;
	wire sw_init = wr_ctrl && REG_WDATA[DDI_CTRL_INIT] &&
		REG_WDATA[DDI_CTRL_EN];
	wire sw_bcast = wr_ctrl && REG_WDATA[DDI_CTRL_BCAST];
	wire [31:0] ctrl_rd = {27'h0, 1'b0, state_q != ST_IDLE, dir_q, en_q};
	wire [31:0] stat_rd = {26'h0, cont_q, first_q, state_q};
	wire [31:0] rd_mux =
		(REG_ADDR == DDI_OFS_CTRL) ? ctrl_rd :
		(REG_ADDR == DDI_OFS_BASE) ? base_q :
		(REG_ADDR == DDI_OFS_STATUS) ? stat_rd :
		(REG_ADDR == DDI_OFS_CUR) ? cur_q :
		(REG_ADDR == DDI_OFS_INT_STAT) ? {29'h0, int_stat} :
		(REG_ADDR == DDI_OFS_INT_MASK) ? {29'h0, int_mask} :
		32'h0000_0000;
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			en_q <= 1'b0;
			dir_q <= DDI_DIR_M2D;
			base_q <= DDI_RST_WORD;
			rdata_q <= DDI_RST_WORD;
		end
		else
		begin
			if (wr_ctrl)
			begin
				en_q <= REG_WDATA[DDI_CTRL_EN];
				// Direction is only taken while the channel is idle
				if (state_q == ST_IDLE)
					dir_q <= REG_WDATA[DDI_CTRL_DIR_LO+1:DDI_CTRL_DIR_LO];
			end
			if (wr_base)
				base_q <= REG_WDATA;
			rdata_q <= REG_RD ? rd_mux : DDI_RST_WORD;
		end
	end
	assign REG_RDATA = rdata_q;

	// ********************************************************
	// Pins from the logic fabric
	// ********************************************************
	ddi_sync #(
		.W(2)
	) u_sync (
		.clk(CLK_SYS),
		.rst_b(RST_B),
		.din({BCAST_IN, DEV_REQ}),
		.rise(pin_rise)
	);
	wire dev_req_ev = pin_rise[0];
	wire bcast_ev = pin_rise[1] | sw_bcast;

	ddi_irq #(
		.N(DDI_INT_N)
	) u_irq (
		.clk(CLK_SYS),
		.rst_b(RST_B),
		.set(int_set),
		.clr_wr(wr_istat),
		.mask_wr(wr_imask),
		.wdata(REG_WDATA[DDI_INT_N-1:0]),
		.status(int_stat),
		.mask(int_mask),
		.irq(IRQ)
	);

	// ********************************************************
	// Descriptor decode
	// ********************************************************
	logic [31:0] desc_q [0:3];
	logic [1:0] widx_q;
	logic req_pend_q;
	logic [15:0] moved_q;
	logic mem_req_q;
	logic mem_we_q;
	logic [31:0] mem_addr_q;
	logic [31:0] mem_wdata_q;
	logic bcast_q;
	logic xstart_q;
	logic [31:0] xsrc_q;
	logic [31:0] xdst_q;
	logic [15:0] xcnt_q;
	logic xcrc_q;
	wire m2m = dir_q == DDI_DIR_M2M;
	wire [1:0] last_idx = m2m ? DDI_LAST_M2M : DDI_LAST_DEV;
	wire [31:0] entry_sz = m2m ? DDI_ENTRY_M2M : DDI_ENTRY_DEV;
	wire [31:0] ctl_w = desc_q[last_idx];
	// Word 0 is the device transfer address, or the m2m source
	wire [31:0] src_w = desc_q[0];
	wire [31:0] dst_w = m2m ? desc_q[2] : desc_q[0];
	wire [31:0] word_ofs = {30'h0, widx_q} * DDI_WORD_BYTES;
	wire [31:0] ctl_addr = cur_q + {30'h0, last_idx} * DDI_WORD_BYTES;
	wire buf_full = ctl_w[DDI_F_BUF];
	// In device modes the memory buffer must hold data to be read, be empty to be written
	wire buf_ok = m2m ||
		(dir_q == DDI_DIR_D2M ? !buf_full : buf_full);
	wire need_req = first_q || !cont_q;
	wire new_buf = (dir_q == DDI_DIR_D2M);
	wire [31:0] wb_word = {moved_q, ctl_w[15:6],
		m2m ? buf_full : new_buf, ctl_w[4:0]};
	wire [1:0] act = ctl_w[1:0];
	wire req_take = state_q == ST_WAIT_REQ && (req_pend_q || dev_req_ev);
	wire wb_done = state_q == ST_WRBACK && mem_req_q && MEM_ACK;
	assign int_set[DDI_INT_DESC] = wb_done && ctl_w[DDI_F_IRQ];
	assign int_set[DDI_INT_BUF_FULL] = state_q == ST_CHECK && !buf_ok &&
		new_buf;
	assign int_set[DDI_INT_HALT] = state_q == ST_NEXT && act == DDI_ACT_HALT;

	// ********************************************************
	// Sequencer
	// ********************************************************
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			req_pend_q <= 1'b0;
		else if (sw_init)
			req_pend_q <= dev_req_ev;
		else
			req_pend_q <= dev_req_ev | (req_pend_q & ~req_take);
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			state_q <= ST_IDLE;
			cur_q <= DDI_RST_WORD;
			widx_q <= 2'h0;
			first_q <= 1'b1;
			cont_q <= 1'b0;
			moved_q <= DDI_RST_CNT;
			mem_req_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_addr_q <= DDI_RST_WORD;
			mem_wdata_q <= DDI_RST_WORD;
			bcast_q <= 1'b0;
			xstart_q <= 1'b0;
			xsrc_q <= DDI_RST_WORD;
			xdst_q <= DDI_RST_WORD;
			xcnt_q <= DDI_RST_CNT;
			xcrc_q <= 1'b0;
			for (int i = 0; i < 4; i++)
				desc_q[i] <= DDI_RST_WORD;
		end
		else
		begin
			xstart_q <= 1'b0;
			bcast_q <= sw_bcast;
			if (sw_init)
			begin
				cur_q <= base_q;
				first_q <= 1'b1;
				widx_q <= 2'h0;
				mem_req_q <= 1'b0;
				state_q <= ST_FETCH;
			end
			else if (!en_q)
			begin
				// Disabling abandons the chain; a bus cycle still ends
				state_q <= ST_IDLE;
				if (MEM_ACK)
					mem_req_q <= 1'b0;
			end
			else
			begin
				unique case (state_q)
					ST_IDLE:
					begin
						// A bus cycle left over from an abort still ends
						if (MEM_ACK)
						begin
							mem_req_q <= 1'b0;
							mem_we_q <= 1'b0;
						end
					end
					ST_FETCH:
					begin
						// One read outstanding at a time, lowest word first
						if (!mem_req_q)
						begin
							mem_req_q <= 1'b1;
							mem_we_q <= 1'b0;
							mem_addr_q <= cur_q + word_ofs;
						end
						else if (MEM_ACK)
						begin
							mem_req_q <= 1'b0;
							desc_q[widx_q] <= MEM_RDATA;
							if (widx_q == last_idx)
								state_q <= ST_CHECK;
							else
								widx_q <= widx_q + 2'h1;
						end
					end
					ST_CHECK:
					begin
						if (!buf_ok)
							state_q <= ST_WAIT_BCAST;
						else if (need_req)
							state_q <= ST_WAIT_REQ;
						else
							state_q <= ST_START;
					end
					ST_WAIT_BCAST:
					begin
						if (bcast_ev)
						begin
							widx_q <= 2'h0;
							state_q <= ST_FETCH;
						end
					end
					ST_WAIT_REQ:
					begin
						if (req_take)
							state_q <= ST_START;
					end
					ST_START:
					begin
						xstart_q <= 1'b1;
						xsrc_q <= src_w;
						xdst_q <= dst_w;
						xcnt_q <= ctl_w[31:DDI_F_CNT_LO];
						xcrc_q <= !ctl_w[DDI_F_CRC_KEEP];
						first_q <= 1'b0;
						state_q <= ST_XFER;
					end
					ST_XFER:
					begin
						if (XFER_DONE)
						begin
							moved_q <= XFER_MOVED;
							state_q <= ST_WRBACK;
						end
					end
					ST_WRBACK:
					begin
						if (!mem_req_q)
						begin
							mem_req_q <= 1'b1;
							mem_we_q <= 1'b1;
							mem_addr_q <= ctl_addr;
							mem_wdata_q <= wb_word;
						end
						else if (MEM_ACK)
						begin
							mem_req_q <= 1'b0;
							mem_we_q <= 1'b0;
							desc_q[last_idx] <= wb_word;
							// Other channels may be waiting on this buffer
							bcast_q <= !m2m;
							state_q <= ST_NEXT;
						end
					end
					ST_NEXT:
					begin
						cont_q <= ctl_w[DDI_F_CONT];
						widx_q <= 2'h0;
						state_q <= ST_FETCH;
						unique case (act)
							DDI_ACT_HALT:
								state_q <= ST_IDLE;
							DDI_ACT_NEXT:
								cur_q <= cur_q + entry_sz;
							DDI_ACT_RESTART:
							begin
								cur_q <= base_q;
								first_q <= 1'b1;
							end
							DDI_ACT_REPEAT:
								cur_q <= cur_q;
						endcase
					end
					default:
						state_q <= ST_IDLE;
				endcase
			end
		end
	end

	assign MEM_REQ = mem_req_q;
	assign MEM_WE = mem_we_q;
	assign MEM_ADDR = mem_addr_q;
	assign MEM_WDATA = mem_wdata_q;
	assign BCAST_OUT = bcast_q;
	assign XFER_START = xstart_q;
	assign XFER_DIR = dir_q;
	assign XFER_SRC = xsrc_q;
	assign XFER_DST = xdst_q;
	assign XFER_CNT = xcnt_q;
	assign XFER_CRC_CLR = xcrc_q;
endmodule

// File: ddi_props.sv
// Port checker for the descriptor interpreter
`timescale 1ns/10ps
module ddi_chk
	import ddi_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic MEM_REQ,
	input wire logic MEM_WE,
	input wire logic [31:0] MEM_ADDR,
	input wire logic [31:0] MEM_WDATA,
	input wire logic [31:0] MEM_RDATA,
	input wire logic MEM_ACK,
	input wire logic XFER_START,
	input wire logic [1:0] XFER_DIR,
	input wire logic [15:0] XFER_CNT,
	input wire logic XFER_CRC_CLR,
	input wire logic XFER_DONE,
	input wire logic [15:0] XFER_MOVED
);
	logic [31:0] ctl_q;
	logic [31:0] ra_q;
	logic [15:0] mv_q;
	logic wb;
	logic dev;
	assign wb = MEM_REQ && MEM_WE;
	assign dev = XFER_DIR != DDI_DIR_M2M;
	// Last word fetched is always the control word
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			ctl_q <= '0;
			ra_q <= '0;
			mv_q <= '0;
		end
		else
		begin
			if (MEM_REQ && MEM_ACK && !MEM_WE)
			begin
				ctl_q <= MEM_RDATA;
				ra_q <= MEM_ADDR;
			end
			if (XFER_DONE)
				mv_q <= XFER_MOVED;
		end
	end
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	property p_hold;
		MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR);
	endproperty
	a_hold: assert property (p_hold) else $error("request dropped");
	property p_gap;
		MEM_REQ && MEM_ACK |=> !MEM_REQ;
	endproperty
	a_gap: assert property (p_gap) else $error("no idle cycle");
	property p_first;
		XFER_START |-> !MEM_REQ;
	endproperty
	a_first: assert property (p_first) else $error("start in fetch");
	property p_cnt;
		XFER_START |-> XFER_CNT == ctl_q[31:16];
	endproperty
	a_cnt: assert property (p_cnt) else $error("bad count");
	property p_crc;
		XFER_START |-> XFER_CRC_CLR == !ctl_q[3];
	endproperty
	a_crc: assert property (p_crc) else $error("bad crc clear");
	property p_buf;
		XFER_START && dev |-> ctl_q[5] == (XFER_DIR == DDI_DIR_M2D);
	endproperty
	a_buf: assert property (p_buf) else $error("buffer not ready");
	property p_wb_cnt;
		$rose(wb) |-> MEM_WDATA[31:16] == mv_q;
	endproperty
	a_wb_cnt: assert property (p_wb_cnt) else $error("bad moved");
	property p_wb_addr;
		$rose(wb) |-> MEM_ADDR == ra_q;
	endproperty
	a_wb_addr: assert property (p_wb_addr) else $error("bad wb addr");
	property p_wb_buf;
		$rose(wb) && dev |-> MEM_WDATA[5] == (XFER_DIR == DDI_DIR_D2M);
	endproperty
	a_wb_buf: assert property (p_wb_buf) else $error("bad flag");
	c_start: cover property (XFER_START);
	c_wb: cover property (wb && MEM_ACK);
	c_m2m: cover property (XFER_START && !dev);
endmodule
bind ddi_desc_interp ddi_chk u_chk (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
	.MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
	.MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK),
	.XFER_START(XFER_START), .XFER_DIR(XFER_DIR), .XFER_CNT(XFER_CNT),
	.XFER_CRC_CLR(XFER_CRC_CLR), .XFER_DONE(XFER_DONE),
	.XFER_MOVED(XFER_MOVED));

// File: ddi_mem_mdl.sv
// Memory and data engine model facing the interpreter
`timescale 1ns/10ps
module ddi_mem_mdl
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] lat,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic mem_ack,
	input wire logic xfer_start,
	output logic xfer_done
);
	logic [31:0] mem [64];
	int n;
	int xn;
	// Read data scrambled outside the ack cycle
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mem_ack <= 1'b0;
			xfer_done <= 1'b0;
			mem_rdata <= '0;
			n = 0;
			xn = 0;
		end
		else
		begin
			mem_ack <= 1'b0;
			xfer_done <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack)
			begin
				if (n < lat)
					n++;
				else
				begin
					n = 0;
					mem_ack <= 1'b1;
					if (mem_we)
						mem[mem_addr[7:2]] <= mem_wdata;
					else
						mem_rdata <= mem[mem_addr[7:2]];
				end
			end
			if (xfer_start)
				xn = lat + 1;
			else if (xn > 0)
			begin
				xn--;
				if (xn == 0)
					xfer_done <= 1'b1;
			end
		end
	end
endmodule

// File: dma_descriptor_interpreter_tb.sv
// Self-checking bench for the descriptor interpreter
`timescale 1ns/10ps
module dma_descriptor_interpreter_tb;
	import ddi_pkg::*;
	logic CLK_SYS = 0, RST_B = 0, REG_WR = 0, REG_RD = 0;
	logic DEV_REQ = 0, BCAST_IN = 0, MEM_REQ, MEM_WE, MEM_ACK, BCAST_OUT;
	logic XFER_START, XFER_CRC_CLR, XFER_DONE, IRQ;
	logic [7:0] REG_ADDR = 0;
	logic [31:0] REG_WDATA = 0, REG_RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA;
	logic [31:0] XFER_SRC, XFER_DST, c;
	logic [15:0] XFER_CNT, XFER_MOVED = 0;
	logic [1:0] XFER_DIR, dir;
	logic [3:0] lat = 0;
	int mismatches, samples_checked, ns, cyc, a, nbo, nbe;
	int aq[$];
	logic [31:0] wq[$];
	always #5 CLK_SYS = ~CLK_SYS;
	ddi_desc_interp dut (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MEM_REQ(MEM_REQ),
		.MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
		.MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .DEV_REQ(DEV_REQ),
		.BCAST_IN(BCAST_IN), .BCAST_OUT(BCAST_OUT), .XFER_DIR(XFER_DIR),
		.XFER_START(XFER_START), .XFER_SRC(XFER_SRC), .XFER_DST(XFER_DST),
		.XFER_CNT(XFER_CNT), .XFER_CRC_CLR(XFER_CRC_CLR), .IRQ(IRQ),
		.XFER_DONE(XFER_DONE), .XFER_MOVED(XFER_MOVED));
	ddi_mem_mdl mdl (.clk(CLK_SYS), .rst_b(RST_B), .lat(lat),
		.mem_req(MEM_REQ), .mem_we(MEM_WE), .mem_addr(MEM_ADDR),
		.mem_wdata(MEM_WDATA), .mem_rdata(MEM_RDATA), .mem_ack(MEM_ACK),
		.xfer_start(XFER_START), .xfer_done(XFER_DONE));
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			mismatches++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task summarize;
		if (mismatches == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge CLK_SYS);
		REG_ADDR <= ad;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLK_SYS);
		REG_WR <= 1'b0;
	endtask
	task rd(input logic [7:0] ad, input logic [31:0] e);
		@(posedge CLK_SYS);
		REG_ADDR <= ad;
		REG_RD <= 1'b1;
		@(posedge CLK_SYS);
		REG_RD <= 1'b0;
		#1 chk("reg", REG_RDATA, e);
	endtask
	// Async inputs held long enough for the synchroniser
	task req(input bit bc);
		@(posedge CLK_SYS);
		if (bc)
			BCAST_IN <= 1'b1;
		else
			DEV_REQ <= 1'b1;
		repeat (4) @(posedge CLK_SYS);
		BCAST_IN <= 1'b0;
		DEV_REQ <= 1'b0;
		repeat (4) @(posedge CLK_SYS);
	endtask
	task wstart(input int n);
		repeat (3000)
			if (ns < n) @(posedge CLK_SYS);
		chk("starts", ns, n);
	endtask
	task go(input logic [1:0] d, input logic [31:0] b);
		dir = d;
		XFER_MOVED <= 16'($urandom);
		lat <= 4'($urandom);
		wr(DDI_OFS_CTRL, 32'h0);
		// Let an abandoned bus cycle finish before restarting
		while (MEM_REQ === 1'b1)
			@(posedge CLK_SYS);
		wr(DDI_OFS_BASE, b);
		wr(DDI_OFS_CTRL, {29'h0, d, 1'b1});
	endtask
	// Flags are buffer, continue, crc keep, irq, then action
	task ent(input int ad, input logic [5:0] f);
		for (int k = 0; k < 4; k++)
			mdl.mem[ad/4+k] = $urandom;
		mdl.mem[ad/4+(dir == DDI_DIR_M2M ? 3 : 1)] =
			{16'($urandom), 10'($urandom), f};
		aq.push_back(ad);
	endtask
	// ************************************************
	// Reference model of each transfer and writeback
	// ************************************************
	always @(posedge CLK_SYS)
	begin
		if (XFER_START === 1'b1)
		begin
			ns++;
			chk("queue", aq.size() > 0, 1);
			chk("dir", XFER_DIR, dir);
			a = aq.size() > 0 ? aq.pop_front() : 0;
			c = mdl.mem[a/4+(dir == DDI_DIR_M2M ? 3 : 1)];
			if (dir != DDI_DIR_D2M)
				chk("src", XFER_SRC, mdl.mem[a/4]);
			if (dir != DDI_DIR_M2D)
				chk("dst", XFER_DST, mdl.mem[a/4+(dir[0] ? 2 : 0)]);
			chk("cnt", XFER_CNT, c[31:16]);
			chk("crc", XFER_CRC_CLR, !c[3]);
			wq.push_back(a + (dir == DDI_DIR_M2M ? 12 : 4));
			wq.push_back({XFER_MOVED, c[15:6],
				dir == DDI_DIR_M2M ? c[5] : dir == DDI_DIR_D2M, c[4:0]});
		end
		if (MEM_REQ && MEM_WE && MEM_ACK)
		begin
			chk("wb_addr", MEM_ADDR, wq.pop_front());
			chk("wb_data", MEM_WDATA, wq.pop_front());
		end
		if (BCAST_OUT === 1'b1)
			nbo++;
		if (REG_WR && REG_ADDR == DDI_OFS_CTRL &&
			REG_WDATA[DDI_CTRL_BCAST])
			nbe++;
		if (MEM_REQ && MEM_WE && MEM_ACK && dir != DDI_DIR_M2M)
			nbe++;
		cyc++;
		if (cyc == 30000)
		begin
			mismatches++;
			summarize();
		end
	end
	initial
	begin
		void'($urandom(36423));
		repeat (8) @(posedge CLK_SYS);
		RST_B <= 1'b1;
		rd(DDI_OFS_BASE, 32'h0);
		rd(8'hfc, 32'h0);
		wr(DDI_OFS_INT_MASK, 32'h7);
		rd(DDI_OFS_INT_MASK, 32'h7);
		go(DDI_DIR_M2D, 32'h40);
		ent(32'h40, {4'b1101, DDI_ACT_NEXT});
		ent(32'h48, {4'b1010, DDI_ACT_HALT});
		wr(DDI_OFS_CTRL, {29'h1, dir, 1'b1});
		repeat (50) @(posedge CLK_SYS);
		chk("starts", ns, 0);
		req(0);
		wstart(2);
		repeat (60) @(posedge CLK_SYS);
		rd(DDI_OFS_INT_STAT, 32'h5);
		chk("irq", IRQ, 1);
		wr(DDI_OFS_INT_STAT, 32'h5);
		rd(DDI_OFS_INT_STAT, 32'h0);
		chk("irq", IRQ, 0);
		wr(DDI_OFS_INT_MASK, 32'h1);
		go(DDI_DIR_D2M, 32'h80);
		ent(32'h80, {4'b0000, DDI_ACT_REPEAT});
		wr(DDI_OFS_CTRL, {29'h1, dir, 1'b1});
		req(0);
		wstart(3);
		repeat (90) @(posedge CLK_SYS);
		chk("starts", ns, 3);
		rd(DDI_OFS_INT_STAT, 32'h2);
		chk("irq", IRQ, 0);
		mdl.mem[32'h84/4][5] = 1'b0;
		aq.push_back(32'h80);
		req(1);
		repeat (60) @(posedge CLK_SYS);
		chk("starts", ns, 3);
		req(0);
		wstart(4);
		repeat (90) @(posedge CLK_SYS);
		// Software empties the buffer and announces it itself
		mdl.mem[32'h84/4][5] = 1'b0;
		aq.push_back(32'h80);
		wr(DDI_OFS_CTRL, {27'h0, 1'b1, 1'b0, dir, 1'b1});
		req(0);
		wstart(5);
		repeat (60) @(posedge CLK_SYS);
		go(DDI_DIR_M2M, 32'hc0);
		ent(32'hc0, {4'b0100, DDI_ACT_NEXT});
		ent(32'hd0, {4'b0110, DDI_ACT_RESTART});
		aq.push_back(32'hc0);
		aq.push_back(32'hd0);
		wr(DDI_OFS_CTRL, {29'h1, dir, 1'b1});
		req(0);
		wstart(7);
		repeat (130) @(posedge CLK_SYS);
		chk("starts", ns, 7);
		rd(DDI_OFS_CUR, 32'h0000_00c0);
		rd(DDI_OFS_STATUS, 32'h0000_0034);
		req(0);
		wstart(9);
		repeat (60) @(posedge CLK_SYS);
		chk("left", aq.size() + wq.size(), 0);
		chk("bcast", nbo, nbe);
		summarize();
	end
endmodule
